// file: rtl/chip_select_decode_pkg.sv
package chip_select_decode_pkg;

   localparam int          NUM_CS      = 4;
   localparam int          ADDR_W      = 24;
   localparam int          WAIT_W      = 3;

   // Register indices on the plain register port
   localparam logic [11:0] ADDR_BASE   = 12'h00f2;
   localparam logic [11:0] ADDR_CS_BASE0 = 12'h0100;
   localparam logic [11:0] ADDR_CS_MASK0 = 12'h0110;
   localparam logic [11:0] ADDR_CS_CFG0  = 12'h0120;
   localparam logic [11:0] ADDR_FC_DMA   = 12'h0130;
   localparam logic [11:0] ADDR_FC_SERIAL_DMA  = 12'h0131;
   localparam logic [11:0] ADDR_FC_RFSH  = 12'h0132;
   localparam logic [11:0] ADDR_STATUS   = 12'h0140;

   // Reset values
   localparam logic [15:0] BASE_RESET  = 16'h0000;
   localparam logic [11:0] CS_BASE_RESET = 12'h0000;
   localparam logic [11:0] CS_MASK_RESET = 12'h0000;
   localparam logic [2:0]  FC_RESET    = 3'h7;

   // Reserved internal area, compared on address bits 11:4
   localparam logic [11:0] RSVD_BASE   = 12'h00f0;
   localparam logic [11:0] RSVD_MASK   = 12'h0ff0;
   localparam logic [2:0]  FC_IACK     = 3'h7;

   typedef enum logic [1:0] {
      SRC_CPU,
      SRC_DMA,
      SRC_SERIAL_DMA,
      SRC_RFSH
   } src_t;

   typedef struct packed {
      logic              valid;
      src_t              src;
      logic              ext_master;
      logic [2:0]        fc;
      logic [ADDR_W-1:0] addr;
      logic              read;
      logic              byte_access;
   } cycle_t;

   typedef enum {
      ST_IDLE,
      ST_WAIT,
      ST_ACK
   } state_t;

endpackage

// file: rtl/chip_select_decode.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Mask ones select address bits compared; gaps give multiple matches.
// R2: No chip select for DMA, serial DMA or refresh with code 111.
// R3: External master code 111 is interrupt acknowledge; selects stay negated.
// R4: External masters must drive function code other than 111.
// R5: Addresses 0F0 to 0FF never activate a chip select.
// R6: Base register lives inside at 0F2; software writes it after reset.
// R7: Each region acknowledges after its own programmed wait states; on overlapping hits the lowest-numbered region's wait states apply.
// R8: External autovector responder asserts autovector, not transfer acknowledge.
// R9: Refresh cycle is a single byte read through the chip selects.
// R10: Function code registers undefined at reset; software loads them. Here they reset to 111.
// R11: Software should program masks as high ones then low zeros.
// R12: Select asserts only on full masked match without exclusions.
module chip_select_decode
   import chip_select_decode_pkg::*;
(
   // Clock, reset and enable
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   input  wire logic              i_enable,
   // Register port
   input  wire logic [11:0]       i_reg_addr,
   input  wire logic [15:0]       i_reg_wdata,
   input  wire logic              i_reg_write,
   input  wire logic              i_reg_read,
   output logic      [15:0]       o_reg_rdata,
   // Bus cycle
   input  wire cycle_t            i_cycle,
   input  wire logic              i_cycle_end,
   // Outputs to the bus
   output logic      [NUM_CS-1:0] o_chip_select,
   output logic                   o_transfer_acknowledge,
   output logic      [2:0]        o_function_code_lines,
   output logic                   o_refresh_byte_read
);

   logic [15:0]        peripheral_base_address;
   logic [11:0]        cs_base [NUM_CS];
   logic [11:0]        cs_mask [NUM_CS];
   logic [WAIT_W-1:0]  cs_wait [NUM_CS];
   logic [2:0]         fc_dma;
   logic [2:0]         fc_serial_dma;
   logic [2:0]         fc_rfsh;
   logic [15:0]        next_rdata;
   logic [2:0]         cyc_fc;
   logic               excluded;
   logic [NUM_CS-1:0]  hit;
   state_t             state;
   state_t             next_state;
   logic [NUM_CS-1:0]  next_cs;
   logic [WAIT_W-1:0]  count;
   logic [WAIT_W-1:0]  next_count;
   logic               next_ack;

   // R1: masked compare on address bits 23:12
   function automatic logic match(input logic [ADDR_W-1:0] a, input logic [11:0] b,
                                  input logic [11:0] m);
      return ((a[23:12] ^ b) & m) == 12'h000;
   endfunction

   // R6: register write path, R10: codes loaded by software
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         peripheral_base_address <= BASE_RESET;
         fc_dma  <= FC_RESET;
         fc_serial_dma <= FC_RESET;
         fc_rfsh <= FC_RESET;
         for (int k = 0; k < NUM_CS; k++) begin
            cs_base[k] <= CS_BASE_RESET;
            cs_mask[k] <= CS_MASK_RESET;
            cs_wait[k] <= '0;
         end
      end else if (i_enable && i_reg_write) begin
         if (i_reg_addr == ADDR_BASE) begin
            peripheral_base_address <= i_reg_wdata;
         end
         if (i_reg_addr == ADDR_FC_DMA) begin
            fc_dma <= i_reg_wdata[2:0];
         end
         if (i_reg_addr == ADDR_FC_SERIAL_DMA) begin
            fc_serial_dma <= i_reg_wdata[2:0];
         end
         if (i_reg_addr == ADDR_FC_RFSH) begin
            fc_rfsh <= i_reg_wdata[2:0];
         end
         for (int k = 0; k < NUM_CS; k++) begin
            if (i_reg_addr == ADDR_CS_BASE0 + 12'(k)) begin
               cs_base[k] <= i_reg_wdata[11:0];
            end
            if (i_reg_addr == ADDR_CS_MASK0 + 12'(k)) begin
               cs_mask[k] <= i_reg_wdata[11:0];
            end
            if (i_reg_addr == ADDR_CS_CFG0 + 12'(k)) begin
               cs_wait[k] <= i_reg_wdata[WAIT_W-1:0];
            end
         end
      end
   end

   always_comb begin
      next_rdata = 16'h0000;
      if (i_reg_addr == ADDR_BASE) begin
         next_rdata = peripheral_base_address;
      end else if (i_reg_addr == ADDR_FC_DMA) begin
         next_rdata = {13'h0000, fc_dma};
      end else if (i_reg_addr == ADDR_FC_SERIAL_DMA) begin
         next_rdata = {13'h0000, fc_serial_dma};
      end else if (i_reg_addr == ADDR_FC_RFSH) begin
         next_rdata = {13'h0000, fc_rfsh};
      end else if (i_reg_addr == ADDR_STATUS) begin
         next_rdata = {12'h000, o_chip_select};
      end
      for (int k = 0; k < NUM_CS; k++) begin
         if (i_reg_addr == ADDR_CS_BASE0 + 12'(k)) begin
            next_rdata = {4'h0, cs_base[k]};
         end
         if (i_reg_addr == ADDR_CS_MASK0 + 12'(k)) begin
            next_rdata = {4'h0, cs_mask[k]};
         end
         if (i_reg_addr == ADDR_CS_CFG0 + 12'(k)) begin
            next_rdata = {13'h0000, cs_wait[k]};
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_enable) begin
         o_reg_rdata <= i_reg_read ? next_rdata : 16'h0000;
      end
   end

   // Function code of the cycle by source
   always_comb begin
      case (i_cycle.src)
         SRC_DMA:  cyc_fc = fc_dma;
         SRC_SERIAL_DMA: cyc_fc = fc_serial_dma;
         SRC_RFSH: cyc_fc = fc_rfsh;
         default:  cyc_fc = i_cycle.fc;
      endcase
   end

   always_comb begin
      excluded = 1'b0;
      // R2: internal units with code 111
      // R3: external interrupt acknowledge
      if (cyc_fc == FC_IACK) begin
         excluded = 1'b1;
      end
      // R5: reserved internal area
      if (((i_cycle.addr[11:0] ^ RSVD_BASE) & RSVD_MASK) == 12'h000) begin
         excluded = 1'b1;
      end
   end

   // R12: masked match without exclusions
   for (genvar g = 0; g < NUM_CS; g++) begin : g_hit
      assign hit[g] = match(i_cycle.addr, cs_base[g], cs_mask[g]) && !excluded;
   end

   // R7: wait-state acknowledge sequencer
   always_comb begin
      next_state = state;
      next_cs    = o_chip_select;
      next_count = count;
      next_ack   = o_transfer_acknowledge;
      case (state)
         ST_IDLE: begin
            next_ack = 1'b0;
            next_cs  = '0;
            if (i_cycle.valid && (hit != '0)) begin
               next_cs    = hit;
               next_count = '0;
               next_state = ST_WAIT;
               for (int k = NUM_CS - 1; k >= 0; k--) begin
                  if (hit[k]) begin
                     next_count = cs_wait[k];
                  end
               end
            end
         end
         ST_WAIT: begin
            if (i_cycle_end) begin
               next_cs    = '0;
               next_state = ST_IDLE;
            end else if (count == '0) begin
               next_ack   = 1'b1;
               next_state = ST_ACK;
            end else begin
               next_count = count - 1'b1;
            end
         end
         ST_ACK: begin
            if (i_cycle_end) begin
               next_ack   = 1'b0;
               next_cs    = '0;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state                  <= ST_IDLE;
         o_chip_select          <= '0;
         count                  <= '0;
         o_transfer_acknowledge <= 1'b0;
         o_function_code_lines  <= 3'h0;
         o_refresh_byte_read    <= 1'b0;
      end else if (i_enable) begin
         state                  <= next_state;
         o_chip_select          <= next_cs;
         count                  <= next_count;
         o_transfer_acknowledge <= next_ack;
         o_function_code_lines  <= cyc_fc;
         // R9: refresh is a byte read
         o_refresh_byte_read    <= i_cycle.valid && (i_cycle.src == SRC_RFSH);
      end
   end

endmodule
`default_nettype wire

// file: tb/chip_select_decode_checker.sv
`timescale 1ns/1ps
`default_nettype none
module chip_select_decode_checker
   import chip_select_decode_pkg::*;
(
   // Watched ports
   input wire logic              i_clock,
   input wire logic              i_rst_n,
   input wire cycle_t            i_cycle,
   input wire logic              i_cycle_end,
   input wire logic [NUM_CS-1:0] o_chip_select,
   input wire logic              o_transfer_acknowledge,
   input wire logic [2:0]        o_function_code_lines,
   input wire logic              o_refresh_byte_read
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   wire logic cs = |o_chip_select;
   wire logic ack = o_transfer_acknowledge;
   property p_rsvd; cs && !$past(cs) |-> $past(i_cycle.addr[11:4]) != 8'h0f; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved hit");
   property p_iack; cs |-> o_function_code_lines != FC_IACK; endproperty
   a_iack: assert property (p_iack) else $error("code 7 select");
   property p_valid; cs && !$past(cs) |-> $past(i_cycle.valid); endproperty
   a_valid: assert property (p_valid) else $error("stray select");
   property p_first; cs && !$past(cs) |-> !ack; endproperty
   a_first: assert property (p_first) else $error("early ack");
   property p_ack; ack |-> cs; endproperty
   a_ack: assert property (p_ack) else $error("lone ack");
   property p_hold; cs && !i_cycle_end |=> $stable(o_chip_select); endproperty
   a_hold: assert property (p_hold) else $error("select moved");
   property p_end; cs && i_cycle_end |=> !cs && !ack; endproperty
   a_end: assert property (p_end) else $error("select kept");
   property p_rfsh; o_refresh_byte_read |-> $past(i_cycle.src) == SRC_RFSH; endproperty
   a_rfsh: assert property (p_rfsh) else $error("stray refresh");
   c_ack: cover property (ack);
   c_rfsh: cover property (o_refresh_byte_read);
   c_multi: cover property ($countones(o_chip_select) > 1);
endmodule
bind chip_select_decode chip_select_decode_checker chip_select_decode_checker_inst (.i_clock,
   .i_rst_n, .i_cycle, .i_cycle_end, .o_chip_select, .o_transfer_acknowledge,
   .o_function_code_lines, .o_refresh_byte_read);
`default_nettype wire

// file: tb/chip_select_decode_partner.sv
`timescale 1ns/1ps
`default_nettype none
module chip_select_decode_partner
   import chip_select_decode_pkg::*;
#(
   parameter int HOLD = 2
)
(
   // Clock and reset
   input  wire logic   i_clock,
   input  wire logic   i_rst_n,
   // Bus side
   input  wire cycle_t i_cycle,
   input  wire logic   i_ack,
   output logic        o_cycle_end
);
   int cnt;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= 0;
         o_cycle_end <= 1'b0;
      end else begin
         cnt <= (i_cycle.valid && !o_cycle_end) ? cnt + 1 : 0;
         o_cycle_end <= i_cycle.valid && !o_cycle_end && ((i_ack && cnt >= HOLD) || cnt == 20);
      end
   end
endmodule
`default_nettype wire

// file: tb/chip_select_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module chip_select_decode_tb;
   import chip_select_decode_pkg::*;
   logic              i_clock, i_rst_n = 1'b0, i_reg_write = 1'b0, i_reg_read = 1'b0;
   logic              i_enable = 1'b1;
   logic              i_cycle_end, o_transfer_acknowledge, o_refresh_byte_read;
   logic [11:0]       i_reg_addr = '0, base [NUM_CS], mask [NUM_CS];
   logic [15:0]       i_reg_wdata = '0, o_reg_rdata;
   logic [NUM_CS-1:0] o_chip_select;
   logic [2:0]        o_function_code_lines, wt [NUM_CS];
   logic [7:0]        ew;
   cycle_t            i_cycle = '0, c;
   int                seed = 16, failures = 0, check_count = 0, r, n;
   chip_select_decode chip_select_decode_inst (.i_clock, .i_rst_n, .i_enable, .i_reg_addr,
      .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata, .i_cycle, .i_cycle_end,
      .o_chip_select, .o_transfer_acknowledge, .o_function_code_lines, .o_refresh_byte_read);
   chip_select_decode_partner #(.HOLD(4)) chip_select_decode_partner_inst (.i_clock, .i_rst_n,
      .i_cycle, .i_ack(o_transfer_acknowledge), .o_cycle_end(i_cycle_end));
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task reg_op(input logic rd, input logic [11:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_read <= rd;
      i_reg_write <= !rd;
      @(posedge i_clock);
      i_reg_read <= 1'b0;
      i_reg_write <= 1'b0;
      #1;
      if (rd)
         check(o_reg_rdata, d);
   endtask
   // Code that the bench loaded for DMA, serial DMA and refresh; CPU cycles use their own code
   function automatic logic [2:0] exp_fc(cycle_t x);
      exp_fc = x.src == SRC_DMA ? 3'h5 : x.src == SRC_RFSH ? 3'h6
         : x.src == SRC_SERIAL_DMA ? 3'h7 : x.fc;
   endfunction
   // Selects in low nibble, acknowledge delay above
   function automatic logic [7:0] exp_of(cycle_t x);
      logic [2:0] f;
      f = exp_fc(x);
      exp_of = 8'hc0;
      for (int k = NUM_CS - 1; k >= 0; k--) begin
         exp_of[k] = ((x.addr[23:12] ^ base[k]) & mask[k]) == 0 && f != 3'h7
            && x.addr[11:4] != 8'h0f;
         if (exp_of[k])
            exp_of[7:4] = 4'(wt[k] + 1);
      end
   endfunction
   task run(input cycle_t x);
      ew = exp_of(x);
      @(posedge i_clock);
      i_cycle <= x;
      @(posedge i_clock);
      #1 check({12'h000, o_chip_select}, {12'h000, ew[3:0]});
      check({13'h0000, o_function_code_lines}, {13'h0000, exp_fc(x)});
      check({15'h0000, o_refresh_byte_read}, {15'h0000, x.src == SRC_RFSH});
      n = 0;
      while (o_transfer_acknowledge !== 1'b1 && n < 12) begin
         @(posedge i_clock);
         #1 n++;
      end
      check(16'(n), {12'h000, ew[7:4]});
      while (i_cycle_end !== 1'b1 && n < 40) begin
         @(posedge i_clock);
         #1 n++;
      end
      @(posedge i_clock);
      i_cycle <= '0;
   endtask
   task end_of_test;
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      failures++;
      end_of_test;
   end
   initial begin
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      reg_op(1'b1, ADDR_BASE, BASE_RESET);
      reg_op(1'b1, ADDR_FC_DMA, 16'(FC_RESET));
      reg_op(1'b0, ADDR_BASE, 16'h5a3c);
      reg_op(1'b1, ADDR_BASE, 16'h5a3c);
      reg_op(1'b1, 12'h0fff, 16'h0000);
      reg_op(1'b1, ADDR_STATUS, 16'h0000);
      // Frozen write is dropped
      @(posedge i_clock);
      i_enable <= 1'b0;
      reg_op(1'b0, ADDR_BASE, 16'h0000);
      @(posedge i_clock);
      i_enable <= 1'b1;
      reg_op(1'b1, ADDR_BASE, 16'h5a3c);
      reg_op(1'b0, ADDR_FC_DMA, 16'h0005);
      reg_op(1'b0, ADDR_FC_SERIAL_DMA, 16'h0007);
      reg_op(1'b0, ADDR_FC_RFSH, 16'h0006);
      for (int k = 0; k < NUM_CS; k++) begin
         base[k] = 12'($random(seed));
         mask[k] = 12'($random(seed));
         // one region keeps a contiguous mask
         if (k == 0)
            mask[k] = 12'hff0;
         wt[k] = 3'($random(seed));
         reg_op(1'b0, 12'(ADDR_CS_BASE0 + k), {4'h0, base[k]});
         reg_op(1'b0, 12'(ADDR_CS_MASK0 + k), {4'h0, mask[k]});
         reg_op(1'b1, 12'(ADDR_CS_MASK0 + k), {4'h0, mask[k]});
         reg_op(1'b0, 12'(ADDR_CS_CFG0 + k), {13'h0000, wt[k]});
      end
      for (int i = 0; i < 44; i++) begin
         r = $random(seed);
         c = '0;
         c.valid = 1'b1;
         c.src = src_t'(r[1:0]);
         c.addr = {base[r[6:5]] ^ (r[18:7] & ~mask[r[6:5]]), r[30:19]};
         case (i)
            0: c.src = SRC_CPU;
            1: c.addr[11:4] = 8'h0f;
            2: c.src = SRC_SERIAL_DMA;
            3: c.src = SRC_RFSH;
            default: ;
         endcase
         c.fc = i == 0 ? FC_IACK : r[4:2];
         c.ext_master = c.src == SRC_CPU && (i == 0 || r[31]);
         if (c.ext_master && i != 0 && c.fc == FC_IACK)
            c.fc = 3'h6;
         c.read = r[20] || c.src == SRC_RFSH;
         c.byte_access = r[21] || c.src == SRC_RFSH;
         run(c);
      end
      end_of_test;
   end
endmodule
`default_nettype wire
